// ### rtl/dram_cycle_timing_wait_control.sv
`timescale 1ns/10ps
`default_nettype none
module dram_cycle_timing_wait_control
    import dram_timing_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_trigger,
    input wire logic board_select,
    input wire logic m1_status,
    input wire logic mem_read_status,
    input wire logic psync,
    input wire logic phi2,
    input wire logic [3:0] bank_select,
    input wire logic [15:0] ram_dout,
    output logic ras_enable,
    output logic [3:0] ras_select,
    output logic refresh_enable,
    output logic refresh_active,
    output logic row_enable,
    output logic [1:0] addr_mux_sel,
    output logic cas_n,
    output logic bus_latch_hold,
    output logic [15:0] data_out,
    output logic ext_cycle,
    output logic ref_cycle,
    output logic stop_cycle_n,
    output logic rdy
);

    // Bus slave state
    logic [CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
    logic wr_pend_q, wr_pend_d;
    logic [31:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [STATUS_WIDTH-1:0] status;
    logic addr_phase;

    // Cycle engine state
    arb_state_t arb_q, arb_d;
    logic [TW-1:0] timer_q, timer_d;
    logic [TW-1:0] len_q, len_d;
    logic running_q, running_d;
    logic ext_req_q, ext_req_d;
    logic ref_req_q, ref_req_d;
    logic ext_cycle_q, ext_cycle_d;
    logic tap1_prev_q, tap2_prev_q;
    logic [15:0] data_q, data_d;
    logic trig_prev_q, psync_prev_q, phi2_prev_q;
    logic shifted_sync_q, shifted_sync_d;
    logic [11:0] refresh_cnt_q, refresh_cnt_d;
    logic [5:0] sync_hold_q, sync_hold_d;
    logic wait_q, wait_d;
    logic conflict_q, conflict_d;
    logic ref_active_prev_q;

    // Registered outputs
    logic ras_enable_q, refresh_enable_q, refresh_active_q, row_enable_q, cas_n_q;
    logic bus_latch_hold_q, stop_cycle_n_q, rdy_q;
    logic [3:0] ras_select_q;
    logic [1:0] addr_mux_sel_q;

    logic [TAP_COUNT-1:0] tap;
    logic ext_lock, ref_lock, any_lock;
    logic stop_tap, long_hold, stop_now, ext_clear;
    logic ref_en_c, ref_act_c, cas_c;
    logic trig_rise, psync_rise, phi2_sel_edge;

    assign ext_lock = (arb_q == ARB_EXT);
    assign ref_lock = (arb_q == ARB_REF);
    assign any_lock = ext_lock | ref_lock;

    // Each tap repeats the lock pulse shifted by its delay; the width is only
    // known once the lock has ended, until then the tap simply stays high
    for (genvar i = 0; i < TAP_COUNT; i++) begin : g_tap
        localparam logic [TW-1:0] AT = ns_to_cycles_up(TAP_NS[i]);
        assign tap[i] = running_q && (timer_q >= AT)
            && (any_lock || ((timer_q - AT) < len_q));
    end

    assign stop_tap = ctrl_q[CTRL_STOP_TAP_BIT] ? tap[TAP_FOURTH] : tap[TAP_THIRD];
    assign long_hold = ctrl_q[CTRL_LONG_BIT] && ext_cycle_q && !mem_read_status
        && shifted_sync_q;
    // Once low, stop stays low until the selected tap falls
    assign stop_now = stop_tap && ((tap[TAP_FIFTH] && !long_hold) || !stop_cycle_n_q);
    assign ext_clear = stop_now && ext_cycle_q;
    assign ref_en_c = ref_lock || (tap[TAP_SECOND] && !ext_cycle_q);
    assign ref_act_c = ref_lock || (tap[TAP_FOURTH] && !ext_cycle_q);
    assign cas_c = tap[TAP_SECOND] && ext_cycle_q;
    assign trig_rise = ext_trigger && !trig_prev_q;
    assign psync_rise = psync && !psync_prev_q;
    assign phi2_sel_edge = ctrl_q[CTRL_PHASE_BIT] ? (!phi2 && phi2_prev_q)
        : (phi2 && !phi2_prev_q);

    // Arbiter, timer and requests
    always_comb begin
        arb_d = arb_q;
        timer_d = timer_q;
        len_d = len_q;
        running_d = running_q;
        ext_req_d = ext_req_q;
        ref_req_d = ref_req_q;
        ext_cycle_d = ext_cycle_q;
        data_d = data_q;
        if (running_q && timer_q != {TW{1'b1}}) begin
            timer_d = timer_q + 1'b1;
        end
        if (any_lock && len_q != {TW{1'b1}}) begin
            len_d = len_q + 1'b1;
        end
        if (running_q && !any_lock && !(|tap) && timer_q > len_q) begin
            running_d = 1'b0;
        end
        unique case (arb_q)
            ARB_IDLE: begin
                // Bus master request wins whenever both are pending
                if (stop_cycle_n_q && !stop_now && ext_req_q) begin
                    arb_d = ARB_EXT;
                end else if (stop_cycle_n_q && !stop_now && ref_req_q) begin
                    arb_d = ARB_REF;
                end
                if (arb_d != ARB_IDLE) begin
                    timer_d = '0;
                    len_d = '0;
                    running_d = 1'b1;
                end
            end
            ARB_EXT, ARB_REF: begin
                if (stop_now) begin
                    arb_d = ARB_IDLE;
                end
            end
            default: begin
                arb_d = ARB_IDLE;
            end
        endcase
        if (tap[TAP_FIRST] && !tap1_prev_q) begin
            ext_cycle_d = ext_lock;
        end
        if (!tap[TAP_SECOND] && tap2_prev_q && ext_cycle_q) begin
            data_d = ram_dout;
        end
        if (trig_rise) begin
            ext_req_d = 1'b1;
        end else if (ext_clear) begin
            ext_req_d = 1'b0;
        end
        if (ext_clear && m1_status) begin
            ref_req_d = 1'b1;
        end else if (refresh_cnt_q >= REFRESH_INTERVAL_C) begin
            ref_req_d = 1'b1;
        end else if (stop_now && !ext_cycle_q && !any_lock) begin
            ref_req_d = 1'b0;
        end else if (stop_now && ref_lock) begin
            ref_req_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arb_q <= ARB_IDLE;
            timer_q <= '0;
            len_q <= '0;
            running_q <= 1'b0;
            ext_req_q <= 1'b0;
            ref_req_q <= 1'b0;
            ext_cycle_q <= 1'b1;
            data_q <= '0;
            tap1_prev_q <= 1'b0;
            tap2_prev_q <= 1'b0;
        end else begin
            arb_q <= arb_d;
            timer_q <= timer_d;
            len_q <= len_d;
            running_q <= running_d;
            ext_req_q <= ext_req_d;
            ref_req_q <= ref_req_d;
            ext_cycle_q <= ext_cycle_d;
            data_q <= data_d;
            tap1_prev_q <= tap[TAP_FIRST];
            tap2_prev_q <= tap[TAP_SECOND];
        end
    end

    // Sync tracking, default refresh count, wait and conflict flops
    always_comb begin
        shifted_sync_d = shifted_sync_q;
        refresh_cnt_d = refresh_cnt_q;
        sync_hold_d = sync_hold_q;
        wait_d = wait_q;
        conflict_d = conflict_q;
        if (psync_rise) begin
            shifted_sync_d = 1'b1;
        end else if (!psync && phi2_sel_edge) begin
            shifted_sync_d = 1'b0;
        end
        if (psync) begin
            sync_hold_d = SYNC_HOLD_C;
        end else if (sync_hold_q != '0) begin
            sync_hold_d = sync_hold_q - 1'b1;
        end
        // Late refresh could slip past the ready sample point
        if (ref_lock) begin
            refresh_cnt_d = '0;
        end else if (!psync && sync_hold_q == '0 && refresh_cnt_q < REFRESH_INTERVAL_C) begin
            refresh_cnt_d = refresh_cnt_q + 1'b1;
        end
        if (psync_rise && board_select && ctrl_q[CTRL_WAIT_EN_BIT]
                && (ctrl_q[CTRL_WAIT_TYPE_BIT] || m1_status)) begin
            wait_d = 1'b1;
        end else if (ext_clear || (!psync && !shifted_sync_q && phi2_sel_edge)) begin
            wait_d = 1'b0;
        end
        if ((trig_rise || (arb_d == ARB_EXT && !ext_lock)) && ref_act_c) begin
            conflict_d = 1'b1;
        end else if (ext_clear) begin
            conflict_d = 1'b0;
        end else if (!ref_act_c && ref_active_prev_q && !ext_req_q) begin
            conflict_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shifted_sync_q <= 1'b0;
            refresh_cnt_q <= '0;
            sync_hold_q <= '0;
            wait_q <= 1'b0;
            conflict_q <= 1'b0;
            trig_prev_q <= 1'b0;
            psync_prev_q <= 1'b0;
            phi2_prev_q <= 1'b0;
            ref_active_prev_q <= 1'b0;
        end else begin
            shifted_sync_q <= shifted_sync_d;
            refresh_cnt_q <= refresh_cnt_d;
            sync_hold_q <= sync_hold_d;
            wait_q <= wait_d;
            conflict_q <= conflict_d;
            trig_prev_q <= ext_trigger;
            psync_prev_q <= psync;
            phi2_prev_q <= phi2;
            ref_active_prev_q <= ref_act_c;
        end
    end

    // Array-facing outputs, one flop each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ras_enable_q <= 1'b0;
            refresh_enable_q <= 1'b0;
            refresh_active_q <= 1'b0;
            row_enable_q <= 1'b1;
            cas_n_q <= 1'b1;
            bus_latch_hold_q <= 1'b0;
            stop_cycle_n_q <= 1'b1;
            rdy_q <= 1'b1;
            ras_select_q <= '0;
            addr_mux_sel_q <= MUX_ROW;
        end else begin
            ras_enable_q <= ext_lock || tap[TAP_FIRST];
            refresh_enable_q <= ref_en_c;
            refresh_active_q <= ref_act_c;
            row_enable_q <= !tap[TAP_FIRST];
            cas_n_q <= !cas_c;
            bus_latch_hold_q <= cas_c;
            stop_cycle_n_q <= !stop_now;
            rdy_q <= !(board_select && (wait_q || conflict_q));
            ras_select_q <= ref_en_c ? 4'hF : bank_select;
            addr_mux_sel_q <= ref_en_c ? MUX_REFRESH
                : (tap[TAP_FIRST] ? MUX_COLUMN : MUX_ROW);
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign status = {shifted_sync_q, wait_q, conflict_q, ext_req_q, ref_req_q,
        refresh_active_q, !ext_cycle_q, ext_cycle_q};

    always_comb begin
        ctrl_d = ctrl_q;
        wr_pend_d = addr_phase && hwrite;
        wr_addr_d = addr_phase ? haddr : wr_addr_q;
        hrdata_d = '0;
        if (wr_pend_q && wr_addr_q[7:0] == CTRL_OFFSET[7:0]) begin
            ctrl_d = hwdata[CTRL_WIDTH-1:0];
        end
        if (addr_phase && !hwrite) begin
            if (haddr[7:0] == CTRL_OFFSET[7:0]) begin
                hrdata_d = {{(32-CTRL_WIDTH){1'b0}}, ctrl_q};
            end else if (haddr[7:0] == STATUS_OFFSET[7:0]) begin
                hrdata_d = {{(32-STATUS_WIDTH){1'b0}}, status};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ras_enable = ras_enable_q;
    assign ras_select = ras_select_q;
    assign refresh_enable = refresh_enable_q;
    assign refresh_active = refresh_active_q;
    assign row_enable = row_enable_q;
    assign addr_mux_sel = addr_mux_sel_q;
    assign cas_n = cas_n_q;
    assign bus_latch_hold = bus_latch_hold_q;
    assign data_out = data_q;
    assign ext_cycle = ext_cycle_q;
    assign ref_cycle = !ext_cycle_q;
    assign stop_cycle_n = stop_cycle_n_q;
    assign rdy = rdy_q;

endmodule // dram_cycle_timing_wait_control
`default_nettype wire

// ### rtl/dram_timing_pkg.sv
package dram_timing_pkg;

    localparam int CLK_PERIOD_NS = 8;

    // Delay-line tap times from cycle start
    localparam int TAP_COUNT = 5;
    localparam int TAP_NS [TAP_COUNT] = '{35, 60, 150, 175, 235};
    localparam int TAP_FIRST = 0;
    localparam int TAP_SECOND = 1;
    localparam int TAP_THIRD = 2;
    localparam int TAP_FOURTH = 3;
    localparam int TAP_FIFTH = 4;
    localparam int TW = 9;

    // Least times round up
    function automatic logic [TW-1:0] ns_to_cycles_up(input int ns);
        return TW'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    // Default refresh interval is a longest time, so it rounds down
    localparam int REFRESH_INTERVAL_NS = 16000;
    localparam logic [11:0] REFRESH_INTERVAL_C = 12'(REFRESH_INTERVAL_NS / CLK_PERIOD_NS);
    // Quiet time after pSYNC before the default count may resume
    localparam int SYNC_HOLD_NS = 250;
    localparam logic [5:0] SYNC_HOLD_C = 6'((SYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Register map
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    localparam int CTRL_LONG_BIT = 0;
    localparam int CTRL_PHASE_BIT = 1;
    localparam int CTRL_WAIT_TYPE_BIT = 2;
    localparam int CTRL_WAIT_EN_BIT = 3;
    localparam int CTRL_STOP_TAP_BIT = 4;
    localparam int CTRL_WIDTH = 5;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
    localparam int ST_EXT_CYCLE_BIT = 0;
    localparam int ST_REF_CYCLE_BIT = 1;
    localparam int ST_REF_ACTIVE_BIT = 2;
    localparam int ST_REF_REQ_BIT = 3;
    localparam int ST_EXT_REQ_BIT = 4;
    localparam int ST_CONFLICT_BIT = 5;
    localparam int ST_WAIT_BIT = 6;
    localparam int ST_SHIFTED_SYNC_BIT = 7;
    localparam int STATUS_WIDTH = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] MUX_ROW = 2'h0;
    localparam logic [1:0] MUX_COLUMN = 2'h1;
    localparam logic [1:0] MUX_REFRESH = 2'h2;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_EXT = 2'b01,
        ARB_REF = 2'b10
    } arb_state_t;

endpackage

// ### verification/dram_timing_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dram_timing_chk
    import dram_timing_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ras_enable,
    input wire logic [3:0] ras_select,
    input wire logic refresh_enable,
    input wire logic refresh_active,
    input wire logic row_enable,
    input wire logic [1:0] addr_mux_sel,
    input wire logic cas_n,
    input wire logic bus_latch_hold,
    input wire logic ext_cycle,
    input wire logic ref_cycle,
    input wire logic stop_cycle_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Type flags must follow the lock that started the column phase
    property p_type;
        (ext_cycle != ref_cycle) and ($fell(row_enable) |-> ext_cycle == !refresh_enable);
    endproperty
    a_type: assert property (p_type) else $error("cycle flags not complementary");
    property p_ref_sel; refresh_enable |-> ras_select == 4'hf; endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("banks not all selected");
    property p_ref_mux; refresh_enable |-> addr_mux_sel == MUX_REFRESH; endproperty
    a_ref_mux: assert property (p_ref_mux) else $error("refresh address missing");
    property p_mux;
        !refresh_enable |-> addr_mux_sel == (row_enable ? MUX_ROW : MUX_COLUMN);
    endproperty
    a_mux: assert property (p_mux) else $error("row column mux wrong");
    property p_cas_ext; !cas_n |-> ext_cycle && !refresh_enable; endproperty
    a_cas_ext: assert property (p_cas_ext) else $error("column strobe in refresh");
    property p_latch; !cas_n |-> bus_latch_hold; endproperty
    a_latch: assert property (p_latch) else $error("bus latch open");
    property p_row_ras; $fell(row_enable) |-> ras_enable; endproperty
    a_row_ras: assert property (p_row_ras) else $error("column phase without row strobe");
    property p_ref_act; $rose(refresh_active) |-> ##[0:3] refresh_enable; endproperty
    a_ref_act: assert property (p_ref_act) else $error("refresh enable late");
    // Width floor only; the exact width is set by the selected stop tap (20 or 23 cycles), not the lock length
    property p_stop_w; $fell(stop_cycle_n) |-> !stop_cycle_n [*8]; endproperty
    a_stop_w: assert property (p_stop_w) else $error("stop pulse too short");
    property p_ahb; hreadyout && !hresp; endproperty
    a_ahb: assert property (p_ahb) else $error("bus response not ready okay");
    c_refresh: cover property ($rose(refresh_active));
    c_cas: cover property ($fell(cas_n));
    c_stop: cover property ($fell(stop_cycle_n) && ext_cycle);
endmodule // dram_timing_chk
`default_nettype wire

// ### verification/s100_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module s100_master_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic hold,
    input wire logic rdy,
    output logic ext_trigger,
    output logic psync,
    output logic phi2,
    output logic done,
    output logic [7:0] waits
);
    logic [3:0] st_q;
    logic [1:0] ph_q;
    // Phase clock runs free, as on the real bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {st_q, ph_q, phi2, ext_trigger, psync, done, waits} <= '0;
        end else begin
            ph_q <= ph_q + 2'h1;
            phi2 <= ph_q[1];
            if (start) begin
                {ext_trigger, psync, st_q, waits, done} <= {2'b11, 4'h1, 8'h00, 1'b0};
            end else if (st_q != 4'h0) begin
                if (st_q >= 4'h4 && !hold) psync <= 1'b0;
                if (!rdy && st_q > 4'h4) waits <= waits + 8'h01;
                else if (st_q == 4'hc) {ext_trigger, done, st_q} <= {2'b01, 4'h0};
                else if (!hold || st_q < 4'h4) st_q <= st_q + 4'h1;
            end
        end
    end
endmodule // s100_master_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import dram_timing_pkg::*;
;
    typedef struct packed {
        logic [4:0] ctrl;
        logic m1;
        logic mrd;
        logic sel;
        logic [15:0] dat;
        logic wt;
    } row_t;
    // Wait enable, wait type and board select against the fetch flag
    localparam row_t ROWS [6] = '{
        '{5'h00, 1'b1, 1'b1, 1'b1, 16'ha5a5, 1'b0}, '{5'h08, 1'b1, 1'b1, 1'b1, 16'h5a5a, 1'b1},
        '{5'h08, 1'b0, 1'b1, 1'b1, 16'h0ff0, 1'b0}, '{5'h0c, 1'b0, 1'b0, 1'b1, 16'hf00f, 1'b1},
        '{5'h0c, 1'b0, 1'b1, 1'b0, 16'h1234, 1'b0}, '{5'h1a, 1'b1, 1'b1, 1'b1, 16'hedcb, 1'b1}};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_trigger, psync, phi2;
    logic m1, mrd, sel, start, hold, done, ras_enable, refresh_enable, refresh_active;
    logic row_enable, cas_n, bus_latch_hold, ext_cycle, ref_cycle, stop_cycle_n, rdy;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, addr_mux_sel;
    logic [3:0] ras_select;
    logic [15:0] ram_dout, data_out;
    logic [7:0] waits;
    int errors = 0, n_tests = 0, cyc = 0, t0, t1;
    dram_cycle_timing_wait_control i_dram_cycle_timing_wait_control (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_trigger(ext_trigger), .board_select(sel),
        .m1_status(m1), .mem_read_status(mrd), .psync(psync), .phi2(phi2),
        .bank_select(4'h1), .ram_dout(ram_dout), .ras_enable(ras_enable),
        .ras_select(ras_select), .refresh_enable(refresh_enable),
        .refresh_active(refresh_active), .row_enable(row_enable), .addr_mux_sel(addr_mux_sel),
        .cas_n(cas_n), .bus_latch_hold(bus_latch_hold), .data_out(data_out),
        .ext_cycle(ext_cycle), .ref_cycle(ref_cycle), .stop_cycle_n(stop_cycle_n), .rdy(rdy));
    s100_master_model i_s100_master_model (.hclk(hclk), .hresetn(hresetn), .start(start),
        .hold(hold), .rdy(rdy), .ext_trigger(ext_trigger), .psync(psync), .phi2(phi2),
        .done(done), .waits(waits));
    always #4 hclk = ~hclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, a, wr};
        @(posedge hclk iff hreadyout);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge hclk iff hreadyout);
        rd = hrdata;
    endtask
    // One master cycle; t1 is row-phase end to stop start, in cycles
    task automatic run(input logic h);
        hold <= h;
        start <= 1'b1;
        @(posedge hclk);
        start <= 1'b0;
        @(negedge hclk iff !row_enable);
        t0 = cyc;
        @(negedge hclk iff !cas_n);
        chk(cyc - t0, 3);
        if (h) begin
            repeat (40) @(posedge hclk);
            hold <= 1'b0;
        end
        @(negedge hclk iff !stop_cycle_n);
        t1 = cyc - t0;
        @(negedge hclk iff stop_cycle_n && done);
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, start, hold, m1, mrd, sel} = '0;
        {haddr, hwdata, htrans, ram_dout} = '0;
        @(negedge hclk);
        chk({ras_enable, ras_select, refresh_enable, refresh_active, row_enable, addr_mux_sel,
            cas_n, bus_latch_hold, ext_cycle, ref_cycle, stop_cycle_n, rdy}, 16'h012b);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ROWS[i]) begin
            {m1, mrd, sel, ram_dout} <= {ROWS[i].m1, ROWS[i].mrd, ROWS[i].sel, ROWS[i].dat};
            ahb(1'b1, CTRL_OFFSET, 32'(ROWS[i].ctrl));
            run(1'b0);
            chk(t1, 25);
            chk(data_out, ROWS[i].dat);
            chk(waits != 8'h00, ROWS[i].wt);
            chk(rdy, 1'b1);
            if (ROWS[i].m1 === 1'b1) begin
                @(negedge hclk iff ref_cycle);
                chk(ras_select, 4'hf);
                @(negedge hclk iff !refresh_active);
            end
            @(posedge hclk);
            $display("row %0d done", i);
        end
        {m1, sel} <= 2'b01;
        for (int k = 0; k < 2; k++) begin
            mrd <= k[0];
            ahb(1'b1, CTRL_OFFSET, 32'h0000_0001);
            run(!k[0]);
            if (k == 0) chk(t1 > 40, 1);
            else chk(t1, 25);
            @(posedge hclk);
        end
        $display("long cycle done");
        ahb(1'b1, CTRL_OFFSET, 32'h0000_0000);
        {m1, mrd} <= 2'b11;
        run(1'b0);
        @(negedge hclk iff refresh_active);
        @(posedge hclk);
        m1 <= 1'b0;
        start <= 1'b1;
        @(posedge hclk);
        start <= 1'b0;
        repeat (5) @(negedge hclk);
        chk(rdy, 1'b0);
        @(negedge hclk iff !cas_n);
        chk(ext_cycle, 1'b1);
        @(negedge hclk iff done && stop_cycle_n);
        chk(rdy, 1'b1);
        @(posedge hclk);
        $display("conflict done");
        ahb(1'b1, CTRL_OFFSET, 32'hffff_ffff);
        ahb(1'b0, CTRL_OFFSET, 32'h0000_0000);
        chk(rd, 32'h0000_001f);
        ahb(1'b1, 32'h0000_0040, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        ahb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk(rd[ST_EXT_CYCLE_BIT], 1'b1);
        chk(rd[ST_REF_CYCLE_BIT], 1'b0);
        $display("registers done");
        // Default refresh after a quiet spell; count must not cut it short
        t0 = cyc;
        @(negedge hclk iff refresh_active);
        chk(cyc - t0 > 1800 && cyc - t0 <= int'(REFRESH_INTERVAL_C) + 3, 1);
        @(negedge hclk iff ref_cycle);
        chk(ras_select, 4'hf);
        @(negedge hclk iff !refresh_active);
        $display("default refresh done");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk({ras_enable, ras_select, refresh_enable, refresh_active, row_enable, addr_mux_sel,
            cas_n, bus_latch_hold, ext_cycle, ref_cycle, stop_cycle_n, rdy}, 16'h012b);
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, CTRL_OFFSET, 32'h0000_0000);
        chk(rd, 32'(CTRL_RESET));
        ahb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk(rd[ST_EXT_CYCLE_BIT], 1'b1);
        $display("reset done");
        stop_test();
    end
endmodule // tb_top
bind dram_cycle_timing_wait_control dram_timing_chk i_dram_timing_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .ras_enable(ras_enable), .ras_select(ras_select), .refresh_enable(refresh_enable),
    .refresh_active(refresh_active), .row_enable(row_enable), .addr_mux_sel(addr_mux_sel),
    .cas_n(cas_n), .bus_latch_hold(bus_latch_hold), .ext_cycle(ext_cycle),
    .ref_cycle(ref_cycle), .stop_cycle_n(stop_cycle_n));
`default_nettype wire
